/* rtl/ssm_top.sv */
/*
  Spread-spectrum profile modulator for a fractional PLL feedback
  divider, with an APB register slave.
  Assumes MCLK is the detector clock at 125 MHz and an APB master.
*/
`timescale 1ns/100ps
`default_nettype none
module ssm_top (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // feedback divider
  output logic [15:0]      FB_FRACTION,
  output logic             FB_UPDATE
);

  logic [31:0] ctrl;
  logic [23:0] set_a;
  logic [23:0] set_b;
  logic [15:0] nfrac;
  logic [8:0]  mod_value;
  logic        mod_update;

  ssm_cfg_if cfg ();

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire access   = PSEL && PENABLE;
  wire hit_ctrl = (PADDR == ssm_pkg::CTRL_OFFSET);
  wire hit_a    = (PADDR == ssm_pkg::SAMPA_OFFSET);
  wire hit_b    = (PADDR == ssm_pkg::SAMPB_OFFSET);
  wire hit_n    = (PADDR == ssm_pkg::NFRAC_OFFSET);
  wire hit_st   = (PADDR == ssm_pkg::STATUS_OFFSET);
  wire mapped   = hit_ctrl | hit_a | hit_b | hit_n | hit_st;
  wire wr       = access && PWRITE && mapped;
  wire rd_setup = PSEL && !PENABLE && !PWRITE;

  assign PREADY  = 1'b1;                 // zero wait states
  assign PSLVERR = access && !mapped;    // unmapped access errors

  // status shows engine state
  wire [31:0] status_word = {15'h0000, cfg.running, 4'h0,
                             cfg.sample_index, cfg.profile_value};
  wire [31:0] read_mux =
      hit_ctrl ? ctrl :
      hit_a    ? {8'h00, set_a} :
      hit_b    ? {8'h00, set_b} :
      hit_n    ? {16'h0000, nfrac} :
      hit_st   ? status_word : 32'h0000_0000;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl   <= ssm_pkg::CTRL_RESET;
      set_a  <= ssm_pkg::SAMP_RESET[23:0];
      set_b  <= ssm_pkg::SAMP_RESET[23:0];
      nfrac  <= ssm_pkg::NFRAC_RESET[15:0];
      PRDATA <= 32'h0000_0000;
    end else begin
      if (wr && hit_ctrl) ctrl  <= PWDATA & 32'h0003_3F7F;
      if (wr && hit_a)    set_a <= PWDATA[23:0];
      if (wr && hit_b)    set_b <= PWDATA[23:0];
      if (wr && hit_n)    nfrac <= PWDATA[15:0];
      // load in the setup cycle so the word already stands in access
      if (rd_setup)       PRDATA <= read_mux;
    end
  end

  // ---------------------------------------------------------------
  // configuration fields to engine
  // ---------------------------------------------------------------
  assign cfg.step_code        = ctrl[ssm_pkg::STEP_LSB +: 4];
  // any code above six acts as six and gives twelve
  assign cfg.quad_code        = (ctrl[ssm_pkg::QUAD_LSB +: 3] > 3'd6) ?
                                3'd6 : ctrl[ssm_pkg::QUAD_LSB +: 3];
  assign cfg.base_offset      = ctrl[ssm_pkg::OFS_LSB +: 6];
  assign cfg.dither_enable    = ctrl[ssm_pkg::DITHER_ENABLE_BIT];
  assign cfg.amplitude_double = ctrl[ssm_pkg::DOUBLE_BIT];
  assign cfg.profile_delta_samples = {set_b, set_a};

  ssm_engine u_engine (
    .clk        (MCLK),
    .rst        (RST),
    .cfg        (cfg),
    .mod_value  (mod_value),
    .mod_update (mod_update)
  );

  // ---------------------------------------------------------------
  // feedback fraction: base fraction plus profile in fraction LSBs
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      FB_FRACTION <= 16'h0000;
      FB_UPDATE   <= 1'b0;
    end else begin
      FB_FRACTION <= 16'(nfrac + {{7{mod_value[8]}}, mod_value});
      FB_UPDATE   <= mod_update;
    end
  end

endmodule : ssm_top
`default_nettype wire

/* shared/ssm_pkg.sv */
/*
  Shared constants for the spread-spectrum profile modulator: register
  offsets, field positions, reset values and widths.
  Assumes an APB bus with 32-bit data and word-aligned registers.
*/
package ssm_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] SAMPA_OFFSET  = 8'h04;
  localparam logic [7:0] SAMPB_OFFSET  = 8'h08;
  localparam logic [7:0] NFRAC_OFFSET  = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int STEP_LSB   = 0;   // step_period_code [3:0]
  localparam int QUAD_LSB   = 4;   // samples_per_quadrant_code [6:4]
  localparam int OFS_LSB    = 8;   // profile_base_offset [13:8]
  localparam int DITHER_ENABLE_BIT   = 16;  // dither_enable
  localparam int DOUBLE_BIT = 17;  // amplitude_double

  // ---------------------------------------------------------------
  // reset values and sizes
  // ---------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] SAMP_RESET  = 32'h0000_0000;
  localparam logic [31:0] NFRAC_RESET = 32'h0000_0000;
  localparam logic [15:0] LFSR_SEED   = 16'hACE1;
  localparam int          NUM_SAMPLES = 12;
  localparam int          SAMPLES_PER_SET = 6;
  localparam int          DELTA_W     = 4;
  localparam int          STEP_ADD    = 2;
  localparam int          OFS_MAX     = 63;

  // traversal quadrant
  typedef enum logic [1:0] {
    Q_RISE_HI, Q_FALL_HI, Q_FALL_LO, Q_RISE_LO
  } ssm_quad_type;

endpackage : ssm_pkg

/* shared/ssm_cfg_if.sv */
/*
  Configuration carrier between the register file and the profile
  engine. Assumes one clock domain; all fields are decoded from registered values.
*/
`timescale 1ns/100ps
`default_nettype none
interface ssm_cfg_if;
  logic [3:0]  step_code;
  logic [2:0]  quad_code;
  logic [5:0]  base_offset;
  logic        dither_enable;
  logic        amplitude_double;
  logic [47:0] profile_delta_samples;
  logic        running;
  logic [7:0]  profile_value;
  logic [3:0]  sample_index;

  modport regs   (output step_code, quad_code, base_offset, dither_enable,
                  amplitude_double, profile_delta_samples,
                  input running, profile_value, sample_index);
  modport engine (input step_code, quad_code, base_offset, dither_enable,
                  amplitude_double, profile_delta_samples,
                  output running, profile_value, sample_index);
endinterface : ssm_cfg_if
`default_nettype wire

/* rtl/ssm_engine.sv */
/*
  Profile engine: steps through delta samples, rebuilds the waveform,
  mirrors it into four quadrants and forms the modulator value.
  Assumes configuration is stable register output on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module ssm_engine (
  // clock and reset
  input  wire logic    clk,
  input  wire logic    rst,
  // configuration and state
  ssm_cfg_if.engine    cfg,
  // modulator value out
  output logic [8:0]   mod_value,
  output logic         mod_update
);

  logic [4:0]  step_count;
  logic [3:0]  index;
  logic [7:0]  accum;
  logic [15:0] lfsr;
  ssm_pkg::ssm_quad_type quad;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire        enabled    = (cfg.step_code != 4'h0);
  wire [4:0]  period     = 5'(cfg.step_code) + 5'(ssm_pkg::STEP_ADD);
  wire [3:0]  nsamples   = {cfg.quad_code, 1'b0};
  // five-bit count so that code 15 still reaches its period of 17
  wire        step_tick  = enabled && (step_count + 5'h01 >= period);
  wire        last_index = (index + 4'h1 >= nsamples);
  // accum holds the magnitude: it grows away from centre in the first
  // upper and the first lower quadrant, the sign comes from below
  wire        rising     = (quad == ssm_pkg::Q_RISE_HI) ||
                           (quad == ssm_pkg::Q_FALL_LO);
  // shrinking quadrants replay the same deltas in reverse order
  wire [3:0]  sel        = rising ? index : 4'(nsamples - 4'h1 - index);
  wire [3:0]  delta      = cfg.profile_delta_samples[4*sel +: 4];
  wire [7:0]  delta_ext  = {{4{delta[3]}}, delta};
  wire [7:0]  next_accum = rising ? 8'(accum + delta_ext)
                                  : 8'(accum - delta_ext);
  wire [7:0]  scaled     = cfg.amplitude_double ? {accum[6:0], 1'b0} : accum;
  wire        below      = (quad == ssm_pkg::Q_FALL_LO) ||
                           (quad == ssm_pkg::Q_RISE_LO);
  wire [8:0]  signed_amp = below ? 9'(-{1'b0, scaled}) : {1'b0, scaled};
  wire [8:0]  next_value = 9'(signed_amp + {3'b000, cfg.base_offset});

  // ---------------------------------------------------------------
  // step counter and quadrant walk
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_count <= 5'h00;
      index      <= 4'h0;
      accum      <= 8'h00;
      quad       <= ssm_pkg::Q_RISE_HI;
    end else if (!enabled || nsamples == 4'h0) begin
      step_count <= 5'h00;
      index      <= 4'h0;
      accum      <= 8'h00;
      quad       <= ssm_pkg::Q_RISE_HI;
    end else if (step_tick) begin
      step_count <= 5'h00;
      accum      <= next_accum;
      index      <= last_index ? 4'h0 : 4'(index + 4'h1);
      if (last_index) begin
        case (quad)
          ssm_pkg::Q_RISE_HI: quad <= ssm_pkg::Q_FALL_HI;
          ssm_pkg::Q_FALL_HI: quad <= ssm_pkg::Q_FALL_LO;
          ssm_pkg::Q_FALL_LO: quad <= ssm_pkg::Q_RISE_LO;
          ssm_pkg::Q_RISE_LO: quad <= ssm_pkg::Q_RISE_HI;
          default:            quad <= ssm_pkg::Q_RISE_HI;
        endcase
      end
    end else begin
      step_count <= 5'(step_count + 5'h01);
    end
  end

  // ---------------------------------------------------------------
  // output value with optional dither
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lfsr       <= ssm_pkg::LFSR_SEED;
      mod_value  <= 9'h000;
      mod_update <= 1'b0;
    end else begin
      mod_update <= step_tick;
      if (step_tick) begin
        lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        mod_value <= cfg.dither_enable ? {next_value[8:1], lfsr[0]}
                                       : next_value;
      end else if (!enabled) begin
        mod_value <= 9'h000;
      end
    end
  end

  assign cfg.running       = enabled;
  assign cfg.profile_value = scaled;
  assign cfg.sample_index  = index;

endmodule : ssm_engine
`default_nettype wire

/* tb/ssm_checker.sv */
/* Checker bound onto the modulator top: bus answers and step timing.
   Assumes it sees only the top ports and a single clock domain. */
`timescale 1ns/100ps
`default_nettype none
module ssm_checker (
  // clock and reset
  input wire logic        MCLK,
  input wire logic        RST,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // divider
  input wire logic [15:0] FB_FRACTION,
  input wire logic        FB_UPDATE
);
  // ---------------------------------------------------------------
  // shadow of the step code
  // ---------------------------------------------------------------
  logic [3:0] step;
  logic [4:0] gap;
  logic [2:0] idle;
  logic       seen;
  wire logic  wr_ctrl;
  wire logic  bad;
  // decode mirrors the map, so no design body is needed
  assign wr_ctrl = PSEL && PENABLE && PWRITE &&
                   PADDR == ssm_pkg::CTRL_OFFSET;
  assign bad = !(PADDR inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10});
  // a control write voids the gap, the step may change mid-count
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      step <= 4'h0;
      gap  <= 5'h00;
      idle <= 3'h0;
      seen <= 1'b0;
    end else begin
      if (wr_ctrl) step <= PWDATA[3:0];
      gap  <= FB_UPDATE ? 5'h01 : gap + {4'h0, gap != 5'h1F};
      seen <= wr_ctrl ? 1'b0 : (seen | FB_UPDATE);
      idle <= (step != 4'h0) ? 3'h0 : idle + {2'h0, idle != 3'h7};
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_acc;
    PSEL && PENABLE;
  endsequence
  sequence s_bad_rd;
    s_acc ##0 (!PWRITE && bad);
  endsequence
  AST_PREADY: assert property (PREADY)
    else $error("pready low");
  AST_ERR_BAD: assert property (s_acc ##0 bad |-> PSLVERR)
    else $error("no error on unmapped access");
  AST_ERR_OK: assert property (!(PSEL && PENABLE && bad) |-> !PSLVERR)
    else $error("error outside unmapped access");
  AST_BAD_ZERO: assert property (s_bad_rd |-> PRDATA == 32'h0)
    else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (!(PSEL && !PENABLE && !PWRITE)
    |=> $stable(PRDATA))
    else $error("read data moved without a read");
  AST_PULSE: assert property (FB_UPDATE |=> !FB_UPDATE)
    else $error("update longer than one cycle");
  AST_PERIOD: assert property (FB_UPDATE && seen
    |-> gap == {1'b0, step} + 5'h02)
    else $error("step period wrong");
  AST_QUIET: assert property (idle >= 3'h4 |-> !FB_UPDATE)
    else $error("update while disabled");
  AST_RESET: assert property (disable iff (1'b0) RST
    |-> !FB_UPDATE && FB_FRACTION == 16'h0 && PRDATA == 32'h0)
    else $error("outputs not cleared in reset");
endmodule // ssm_checker
bind ssm_top ssm_checker chk_u (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .FB_FRACTION(FB_FRACTION), .FB_UPDATE(FB_UPDATE));
`default_nettype wire

/* tb/ssm_top_tb_top.sv */
/* Bench for the modulator top: registers over APB, profiles at the
   divider outputs. Assumes design and checker compiled before it. */
`timescale 1ns/100ps
`default_nettype none
module ssm_top_tb_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        MCLK = 1'b0;
  logic        RST = 1'b0;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic [15:0] FB_FRACTION;
  logic        FB_UPDATE;
  logic [31:0] rdat;
  logic        rerr;
  logic [15:0] ev [0:47];
  logic [15:0] obs [0:53];
  int          failures = 0;
  int          total_checks = 0;
  int          upd;
  // 125 MHz detector clock
  always #4 MCLK = ~MCLK;
  ssm_top dut_u (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .FB_FRACTION(FB_FRACTION), .FB_UPDATE(FB_UPDATE));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // answer is taken at the edge that samples pready high, then released
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    rerr = PSLVERR;
    rdat = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic x);
    apb(1'b0, a, 32'h0);
    cmp(rdat, e);
    cmp({31'h0, rerr}, {31'h0, x});
  endtask
  // the phase of the run is unknown, so every rotation is tried
  task automatic prof(input logic [3:0] st, input logic [2:0] q,
    input logic [5:0] ofs, input logic dbl, input logic dth,
    input logic [47:0] dl);
    int n, acc, k, hit, lsb;
    logic [15:0] m;
    n = 2 * q;
    acc = 0;
    for (k = 0; k < 4 * n; k++) begin
      case (k / n)
        0: acc += $signed(dl[4 * (k % n) +: 4]);
        1: acc -= $signed(dl[4 * (n - 1 - k % n) +: 4]);
        2: acc -= $signed(dl[4 * (k % n) +: 4]);
        default: acc += $signed(dl[4 * (n - 1 - k % n) +: 4]);
      endcase
      ev[k] = 16'h0100 + 16'(ofs) + 16'(dbl ? 2 * acc : acc);
    end
    @(posedge MCLK);
    RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    apb(1'b1, ssm_pkg::SAMPA_OFFSET, {8'h0, dl[23:0]});
    apb(1'b1, ssm_pkg::SAMPB_OFFSET, {8'h0, dl[47:24]});
    apb(1'b1, ssm_pkg::NFRAC_OFFSET, 32'h0000_0100);
    apb(1'b1, ssm_pkg::CTRL_OFFSET,
        {14'h0, dbl, dth, 2'h0, ofs, 1'b0, q, st});
    for (k = 0; k < 4 * n + 6; k++) begin
      do @(posedge MCLK); while (FB_UPDATE !== 1'b1);
      obs[k] = FB_FRACTION;
    end
    m = dth ? 16'hFFFE : 16'hFFFF;
    hit = 0;
    lsb = 0;
    for (int r = 0; r < 4 * n; r++) begin
      int ok, d;
      ok = 1;
      d = 0;
      for (int j = 2; j < 4 * n + 6; j++) begin
        if (((obs[j] ^ ev[(r + j) % (4 * n)]) & m) !== 16'h0) ok = 0;
        d += int'(obs[j][0] ^ ev[(r + j) % (4 * n)][0]);
      end
      if (ok == 1) hit = 1;
      if (ok == 1) lsb = d;
    end
    cmp(32'(hit), 32'h1);
    if (dth) cmp(32'(lsb != 0), 32'h1);
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    // raised by a scheduled update so the flops see a real rising edge
    RST <= 1'b1;
    repeat (6) @(posedge MCLK);
    RST <= 1'b0;
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0, 1'b0);
    apb(1'b1, ssm_pkg::STATUS_OFFSET, 32'hFFFF_FFFF);
    rd(ssm_pkg::STATUS_OFFSET, 32'h0, 1'b0);
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    cmp({31'h0, rerr}, 32'h1);
    rd(8'h14, 32'h0, 1'b1);
    apb(1'b1, ssm_pkg::SAMPA_OFFSET, 32'h00AB_CDEF);
    rd(ssm_pkg::SAMPA_OFFSET, 32'h00AB_CDEF, 1'b0);
    apb(1'b1, ssm_pkg::SAMPB_OFFSET, 32'h0012_3456);
    rd(ssm_pkg::SAMPB_OFFSET, 32'h0012_3456, 1'b0);
    apb(1'b1, ssm_pkg::NFRAC_OFFSET, 32'h0000_BEEF);
    rd(ssm_pkg::NFRAC_OFFSET, 32'h0000_BEEF, 1'b0);
    apb(1'b1, ssm_pkg::CTRL_OFFSET, 32'h0003_2A35);
    rd(ssm_pkg::CTRL_OFFSET, 32'h0003_2A35, 1'b0);
    apb(1'b1, ssm_pkg::CTRL_OFFSET, 32'h0000_0510);
    repeat (4) @(posedge MCLK);
    upd = 0;
    repeat (40) begin
      @(posedge MCLK);
      upd += int'(FB_UPDATE);
    end
    cmp(32'(upd), 32'h0);
    rd(ssm_pkg::STATUS_OFFSET, 32'h0, 1'b0);
    prof(4'h1, 3'h1, 6'd10, 1'b0, 1'b0, 48'h23);
    prof(4'h1, 3'h1, 6'd10, 1'b1, 1'b0, 48'h23);
    prof(4'h1, 3'h1, 6'd10, 1'b0, 1'b1, 48'h23);
    prof(4'h2, 3'h4, 6'd20, 1'b0, 1'b0, 48'hF2_111111);
    prof(4'hE, 3'h1, 6'd63, 1'b0, 1'b0, 48'h0);
    report_and_stop();
  end
  // watchdog far beyond the several hundred cycles the tests need
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end
endmodule // ssm_top_tb_top
`default_nettype wire
